// ---- rtl/oltw_defines.vh ----
// Constants for the open-loop tuning word register bank
`ifndef OLTW_DEFINES_VH
`define OLTW_DEFINES_VH

// Register indices; the APB byte address is four times the index
`define OLTW_IDX_CONTROL 12'h100
`define OLTW_IDX_STATUS 12'h101
`define OLTW_IDX_BYTE0 12'h1A6
`define OLTW_IDX_BYTE1 12'h1A7
`define OLTW_IDX_BYTE2 12'h1A8
`define OLTW_IDX_BYTE3 12'h1A9
`define OLTW_IDX_BYTE4 12'h1AA
`define OLTW_IDX_BYTE5 12'h1AB
`define OLTW_BYTE_COUNT 6

// Byte address handling
`define OLTW_ADDR_LSB 2
`define OLTW_IDX_W 12
`define OLTW_ADDR_LOW 2'h0

// Control register fields
`define OLTW_CTRL_LOOP_CLOSED 0
`define OLTW_CTRL_EST_DISABLE 4
`define OLTW_CTRL_RESET 8'h00

// Status register fields
`define OLTW_STAT_PENDING 0
`define OLTW_STAT_LOOP_CLOSED 1
`define OLTW_STAT_EST_DISABLE 2

// Reset values
`define OLTW_WORD_RESET 48'h000000000000
`define OLTW_DATA_ZERO 32'h00000000

`endif

// ---- rtl/oltw_accum.v ----
// Phase accumulator of the synthesizer, advanced by the tuning word every clock
`timescale 1ns/1ps
module oltw_accum #(
  parameter WIDTH = 48
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Tuning word
  input wire [WIDTH-1:0] i_tuning_word,
  // Accumulated phase
  output reg [WIDTH-1:0] o_phase
);

  // Out of reset, phase only adds the current word, so a word change never jumps phase
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_phase <= {WIDTH{1'b0}};
    end else begin
      o_phase <= o_phase + i_tuning_word;
    end
  end

endmodule

// ---- rtl/oltw_top.v ----
// Open-loop tuning word register bank with APB access and synthesizer drive
`timescale 1ns/1ps
`include "oltw_defines.vh"
module oltw_top #(
  parameter WORD_W = 48,
  parameter ADDR_W = 16,
  parameter [47:0] STRAP_BASE_WORD = 48'h100000000000,
  parameter [47:0] STRAP_STEP_WORD = 48'h010000000000
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // Startup straps, bit 0 is the first pin, bit 3 the last
  input wire [3:0] i_startup_strap_pins,
  // Closed-loop tuning word from the loop filter
  input wire [WORD_W-1:0] i_loop_tuning_word,
  // Synthesizer drive
  output reg [WORD_W-1:0] o_dds_tuning_word,
  output wire [WORD_W-1:0] o_dds_phase,
  // Loop control and frequency estimate seed
  output reg o_loop_closed,
  output reg o_estimate_load,
  output reg [WORD_W-1:0] o_estimate_seed
);

  // Bus decode
  wire [`OLTW_IDX_W-1:0] bus_index;
  wire bus_access;
  wire bus_setup_access;
  wire bus_commit;
  wire addr_aligned;
  reg addr_hit;
  reg [7:0] byte_read;
  reg [31:0] read_word;

  // State
  reg [WORD_W-1:0] staged_word_reg;
  reg [WORD_W-1:0] active_word_reg;
  reg [7:0] control_reg;
  reg strap_load_reg;
  reg est_disable_prev_reg;
  reg [WORD_W-1:0] strap_word;

  // Next values
  reg [WORD_W-1:0] staged_word_next;
  reg [WORD_W-1:0] active_word_next;
  reg [7:0] control_next;
  reg pready_next;
  reg [31:0] prdata_next;
  reg pslverr_next;
  reg [WORD_W-1:0] dds_word_next;
  reg estimate_load_next;

  wire loop_closed;
  wire est_disable;
  wire write_byte5;
  wire pending;

  integer i;
  integer j;

  assign bus_index = i_paddr[`OLTW_IDX_W+`OLTW_ADDR_LSB-1:`OLTW_ADDR_LSB];
  assign addr_aligned = (i_paddr[`OLTW_ADDR_LSB-1:0] == `OLTW_ADDR_LOW);
  assign bus_access = i_psel & i_penable;
  assign bus_setup_access = bus_access & ~o_pready;
  assign bus_commit = bus_access & o_pready & i_pwrite & addr_hit;
  assign loop_closed = control_reg[`OLTW_CTRL_LOOP_CLOSED];
  assign est_disable = control_reg[`OLTW_CTRL_EST_DISABLE];
  assign write_byte5 = bus_commit & (bus_index == `OLTW_IDX_BYTE5);
  assign pending = (staged_word_reg != active_word_reg);

  // Default word from the strap levels
  always @* begin
    strap_word = STRAP_BASE_WORD + (STRAP_STEP_WORD * {44'h00000000000, i_startup_strap_pins});
  end

  // Address decode and read mux
  always @* begin
    addr_hit = 1'b0;
    byte_read = 8'h00;
    read_word = `OLTW_DATA_ZERO;
    if (addr_aligned && (i_paddr[ADDR_W-1:`OLTW_IDX_W+`OLTW_ADDR_LSB] == 0)) begin
      // Byte registers first, then control and status
      for (i = 0; i < `OLTW_BYTE_COUNT; i = i + 1) begin
        if (bus_index == `OLTW_IDX_BYTE0 + i) begin
          addr_hit = 1'b1;
          byte_read = staged_word_reg[i*8 +: 8];
        end
      end
      if (addr_hit) begin
        read_word = {24'h000000, byte_read};
      end else if (bus_index == `OLTW_IDX_CONTROL) begin
        addr_hit = 1'b1;
        read_word = {24'h000000, control_reg};
      end else if (bus_index == `OLTW_IDX_STATUS) begin
        addr_hit = 1'b1;
        read_word[`OLTW_STAT_PENDING] = pending;
        read_word[`OLTW_STAT_LOOP_CLOSED] = loop_closed;
        read_word[`OLTW_STAT_EST_DISABLE] = est_disable;
      end
    end
  end

  // Next APB answer: one wait state, read data and error only beside pready
  always @* begin
    pready_next = bus_setup_access;
    prdata_next = `OLTW_DATA_ZERO;
    pslverr_next = 1'b0;
    if (bus_setup_access) begin
      prdata_next = i_pwrite ? `OLTW_DATA_ZERO : read_word;
      pslverr_next = ~addr_hit;
    end
  end

  // APB answer registers
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= `OLTW_DATA_ZERO;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= pready_next;
      o_prdata <= prdata_next;
      o_pslverr <= pslverr_next;
    end
  end

  // Strap capture happens on the first edge after reset release
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      strap_load_reg <= 1'b1;
    end else begin
      strap_load_reg <= 1'b0;
    end
  end

  // Next values of the staged bytes, control and the committed word
  always @* begin
    staged_word_next = staged_word_reg;
    active_word_next = active_word_reg;
    control_next = control_reg;
    if (strap_load_reg) begin
      staged_word_next = strap_word;
      active_word_next = strap_word;
    end else begin
      if (bus_commit) begin
        for (j = 0; j < `OLTW_BYTE_COUNT; j = j + 1) begin
          if (bus_index == `OLTW_IDX_BYTE0 + j) begin
            staged_word_next[j*8 +: 8] = i_pwdata[7:0];
          end
        end
        if (bus_index == `OLTW_IDX_CONTROL) begin
          control_next = i_pwdata[7:0];
        end
      end
      // Top byte write commits all six bytes at once
      if (write_byte5) begin
        active_word_next = {i_pwdata[7:0], staged_word_reg[WORD_W-9:0]};
      end
    end
  end

  // Staged bytes, control and the committed word
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      staged_word_reg <= `OLTW_WORD_RESET;
      active_word_reg <= `OLTW_WORD_RESET;
      control_reg <= `OLTW_CTRL_RESET;
    end else begin
      staged_word_reg <= staged_word_next;
      active_word_reg <= active_word_next;
      control_reg <= control_next;
    end
  end

  // Next word toward the synthesizer and the estimate seed pulse
  always @* begin
    dds_word_next = loop_closed ? i_loop_tuning_word : active_word_reg;
    estimate_load_next = est_disable & (~est_disable_prev_reg | (loop_closed & ~o_loop_closed));
  end

  // Synthesizer word select and estimate seeding
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_dds_tuning_word <= `OLTW_WORD_RESET;
      o_loop_closed <= 1'b0;
      o_estimate_load <= 1'b0;
      o_estimate_seed <= `OLTW_WORD_RESET;
      est_disable_prev_reg <= 1'b0;
    end else begin
      o_dds_tuning_word <= dds_word_next;
      o_loop_closed <= loop_closed;
      est_disable_prev_reg <= est_disable;
      o_estimate_seed <= active_word_reg;
      o_estimate_load <= estimate_load_next;
    end
  end

  // Phase accumulator
  oltw_accum #(
    .WIDTH(WORD_W)
  ) u_accum (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_tuning_word(o_dds_tuning_word),
    .o_phase(o_dds_phase)
  );

endmodule

// ---- test/oltw_checker.sv ----
// Checker for the open-loop tuning word bank
`timescale 1ns/1ps
module oltw_checker (
  // APB
  input wire i_clock, i_rst, i_psel, i_penable, i_pwrite, o_pready,
  input wire [15:0] i_paddr,
  input wire [31:0] o_prdata,
  // Synthesizer
  input wire o_loop_closed, o_estimate_load,
  input wire [47:0] i_loop_tuning_word, o_dds_tuning_word, o_dds_phase, o_estimate_seed
);
  wire top_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == 16'h06AC;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wait_state_a: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
    else $error("pready timing wrong");
  byte_data_a: assert property (o_pready |-> o_prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  phase_cont_a: assert property (o_dds_phase == $past(o_dds_phase) + $past(o_dds_tuning_word))
    else $error("phase not continuous");
  open_word_a: assert property ((!o_loop_closed)[*3] |-> o_dds_tuning_word == o_estimate_seed)
    else $error("open word not driven");
  closed_word_a: assert property (o_loop_closed[*3] |-> o_dds_tuning_word == $past(i_loop_tuning_word))
    else $error("loop word not driven");
  seed_pulse_a: assert property (o_estimate_load |=> !o_estimate_load)
    else $error("seed load not a pulse");
  word_commit_a: assert property ($changed(o_dds_tuning_word) && !o_loop_closed && !$past(o_loop_closed)
    && !$past(o_loop_closed, 2) |-> $past(top_wr, 2) || $past(i_rst, 3)) else $error("word changed early");
  cover property (o_estimate_load);
  cover property (top_wr);
  cover property (o_loop_closed);
endmodule
bind oltw_top oltw_checker chk (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .o_pready(o_pready), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_loop_closed(o_loop_closed), .o_estimate_load(o_estimate_load), .i_loop_tuning_word(i_loop_tuning_word),
  .o_dds_tuning_word(o_dds_tuning_word), .o_dds_phase(o_dds_phase), .o_estimate_seed(o_estimate_seed));

// ---- test/oltw_tb.sv ----
// Testbench for the open-loop tuning word bank
`timescale 1ns/1ps
module testbench;
  localparam [47:0] B = 48'h200000000000;
  localparam [47:0] S = 48'h000100000000;
  reg i_clock = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  reg [15:0] i_paddr = 0;
  reg [31:0] i_pwdata = 0;
  reg [3:0] i_startup_strap_pins = 0;
  reg [47:0] i_loop_tuning_word = 0, w, e;
  wire o_pready, o_pslverr, o_loop_closed, o_estimate_load;
  wire [31:0] o_prdata;
  wire [47:0] o_dds_tuning_word, o_dds_phase, o_estimate_seed;
  reg [32:0] q[$];
  integer failures = 0, cmp_count = 0, cyc = 0, loads = 0, i;
  oltw_top #(.STRAP_BASE_WORD(B), .STRAP_STEP_WORD(S)) dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_startup_strap_pins(i_startup_strap_pins), .i_loop_tuning_word(i_loop_tuning_word),
    .o_dds_tuning_word(o_dds_tuning_word), .o_dds_phase(o_dds_phase), .o_loop_closed(o_loop_closed),
    .o_estimate_load(o_estimate_load), .o_estimate_seed(o_estimate_seed));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  task chk(input string n, input [47:0] x, input [47:0] y);
    begin
      cmp_count = cmp_count + 1;
      if (x !== y) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", n, x, y);
      end
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // One APB transfer; the expected answer goes to the queue
  task apb(input wr, input [15:0] a, input [31:0] d, input [32:0] x);
    begin
      q.push_back(x);
      i_psel <= 1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1;
      do @(posedge i_clock); while (o_pready !== 1'b1);
      i_psel <= 0;
      i_penable <= 0;
      @(posedge i_clock);
    end
  endtask
  always @(posedge i_clock) begin
    if (o_pready === 1'b1) chk("apb answer", q.pop_front(), {o_pslverr, o_prdata});
    if (o_estimate_load === 1'b1) loads <= loads + 1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      close_out;
    end
  end
  initial begin
    i = $urandom(32'h31B73433);
    w = 48'({$urandom, $urandom});
    @(posedge i_clock);
    i_startup_strap_pins <= 4'($urandom);
    i_loop_tuning_word <= 48'({$urandom, $urandom});
    repeat (4) @(posedge i_clock);
    i_rst <= 0;
    repeat (4) @(posedge i_clock);
    e = B + i_startup_strap_pins * S;
    chk("strap word", e, o_dds_tuning_word);
    for (i = 0; i < 5; i = i + 1) apb(1, 16'h0698 + 4 * i, w[8*i+:8], 0);
    apb(0, 16'h0404, 0, w[39:0] != e[39:0]);
    chk("staged word", e, o_dds_tuning_word);
    apb(1, 16'h06AC, w[47:40], 0);
    @(posedge i_clock);
    chk("open word", w, o_dds_tuning_word);
    for (i = 0; i < 6; i = i + 1) apb(0, 16'h0698 + 4 * i, 0, w[8*i+:8]);
    apb(0, 16'h0699, 0, 33'h100000000);
    $display("word tests done");
    apb(1, 16'h0400, 32'h00000010, 0);
    repeat (2) @(posedge i_clock);
    chk("seed load", 1, loads);
    chk("seed word", w, o_estimate_seed);
    apb(1, 16'h0400, 32'h00000011, 0);
    repeat (3) @(posedge i_clock);
    chk("loop flag", 1, o_loop_closed);
    chk("loop word", i_loop_tuning_word, o_dds_tuning_word);
    chk("seed reload", 2, loads);
    apb(1, 16'h0400, 32'h00000000, 0);
    repeat (3) @(posedge i_clock);
    chk("reopened word", w, o_dds_tuning_word);
    $display("control tests done");
    i_rst <= 1;
    i_startup_strap_pins <= ~i_startup_strap_pins;
    repeat (5) @(posedge i_clock);
    i_rst <= 0;
    repeat (4) @(posedge i_clock);
    e = B + i_startup_strap_pins * S;
    chk("strap after reset", e, o_dds_tuning_word);
    apb(0, 16'h06AC, 0, e[47:40]);
    $display("reset tests done");
    close_out;
  end
endmodule
